//--- design/tmr_ctrl.sv
// 16-bit timer: counter, prescaler, event flags and channel 0 control
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps

// Notes on behaviour
// [RQ1] low byte read latches high byte
// [RQ2] any low byte write clears counter
// [RQ3] channel flags at bits 7..5, software cleared
// [RQ4] wrap flag on terminal or zero turnaround
// [RQ5] prescaler divides tick by 1/8/32/128
// [RQ6] prescaler counter not reset by writes
// [RQ7] mode 00 holds the counter
// [RQ8] mode 01 counts 0 to ffff, wraps
// [RQ9] mode 10 counts 0 to compare, restarts
// [RQ10] mode 11 counts up then down
// [RQ11] trigger select: pin or masked radio events
// [RQ12] output action on compare equality
// [RQ13] set, clear, toggle actions; 101-111 reserved
// [RQ14] code 011 set up, clear zero/down
// [RQ15] code 100 clear up, set zero/down
// [RQ16] bit 2 selects capture or compare
// [RQ17] capture edge none/rise/fall/both
// [RQ18] flags set regardless of masks
// [RQ19] interrupt needs flag, mask, global enable
// [RQ20] writing one leaves a flag unchanged
module tmr_ctrl (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // timer tick and compare value
    input wire logic tick_i,
    input wire logic [15:0] period_compare_value_i,
    // capture sources
    input wire logic capture_pin_i,
    input wire logic [7:0] radio_event_i,
    input wire logic [7:0] radio_event_mask_i,
    // other channels and interrupt gating
    input wire logic chan1_event_i,
    input wire logic chan2_event_i,
    input wire logic chan1_irq_enable_i,
    input wire logic chan2_irq_enable_i,
    input wire logic wrap_irq_enable_i,
    input wire logic timer_irq_enable_i,
    // results
    output logic irq_o,
    output logic chan0_out_o,
    output logic capture_o,
    output logic [15:0] capture_value_o,
    output logic [15:0] counter_value_o
);

    // register state
    logic [15:0] cnt_q, cnt_d; // counter_value
    tmr_pkg::tmr_dir_t dir_q, dir_d; // up/down direction
    logic [7:0] high_latch_q; // buffered high byte
    logic [6:0] presc_q; // free prescaler count
    logic [1:0] div_q; // divider code
    logic [1:0] mode_q; // operating mode
    logic [7:0] ch0_ctl_q; // channel 0 control
    logic chan2_event_flag_q;
    logic chan1_event_flag_q;
    logic chan0_event_flag_q;
    logic wrap_event_flag_q;
    logic [7:0] rdata_q; // read data, one cycle late
    logic out_q; // channel 0 output
    logic cap_q; // capture strobe
    logic [15:0] cap_val_q; // captured count
    // pin synchroniser and edge history
    logic pin_s1_q, pin_s2_q, pin_s3_q;

    // address decode
    wire sel_low = reg_addr_i == tmr_pkg::ADDR_CNT_LOW;
    wire sel_high = reg_addr_i == tmr_pkg::ADDR_CNT_HIGH;
    wire sel_ctl = reg_addr_i == tmr_pkg::ADDR_CTL;
    wire sel_ch0 = reg_addr_i == tmr_pkg::ADDR_CH0_CTL;
    wire clr_wr = reg_wr_i & sel_low;
    wire ctl_wr = reg_wr_i & sel_ctl;
    wire ch0_wr = reg_wr_i & sel_ch0;
    wire low_rd = reg_rd_i & sel_low;

    // channel 0 fields
    wire trig_sel = ch0_ctl_q[tmr_pkg::CH_TRIG_SEL];
    wire ch0_irq_en = ch0_ctl_q[tmr_pkg::CH_IRQ_EN];
    wire [2:0] act = ch0_ctl_q[tmr_pkg::CH_ACT_LSB +: 3];
    wire cmp_mode = ch0_ctl_q[tmr_pkg::CH_CMP_MODE];
    wire [1:0] edge_sel = ch0_ctl_q[tmr_pkg::CH_EDGE_LSB +: 2];
    wire [15:0] cmp = period_compare_value_i;

    // prescaler step: low bits of the free count all ones
    // [RQ5] divider mask select
    wire [6:0] div_mask =
        (div_q == 2'h0) ? tmr_pkg::DIV1_MASK :
        (div_q == 2'h1) ? tmr_pkg::DIV8_MASK :
        (div_q == 2'h2) ? tmr_pkg::DIV32_MASK :
        tmr_pkg::DIV128_MASK;
    wire step = tick_i & ((presc_q & div_mask) == div_mask);
    wire run = mode_q != tmr_pkg::MODE_HOLD;

    // [RQ6] prescaler free runs, never cleared by writes
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            presc_q <= 7'h00;
        end else if (tick_i) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    // counter next value; turn flags a wrap or zero turnaround
    logic turn;
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        turn = 1'b0;
        // [RQ2] clear wins over counting
        if (clr_wr) begin
            cnt_d = tmr_pkg::RST_CNT;
            dir_d = tmr_pkg::DIR_UP;
        end else if (step) begin
            case (mode_q)
                // [RQ8] full range wrap
                tmr_pkg::MODE_FREE: begin
                    cnt_d = cnt_q + 16'h0001;
                    turn = cnt_q == 16'hffff;
                end
                // [RQ9] restart after compare value
                tmr_pkg::MODE_MOD: begin
                    if (cnt_q >= cmp) begin
                        cnt_d = 16'h0000;
                        turn = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
                // [RQ10] up to compare, down to zero
                tmr_pkg::MODE_UPDN: begin
                    if (dir_q == tmr_pkg::DIR_UP) begin
                        if (cnt_q >= cmp) begin
                            dir_d = tmr_pkg::DIR_DOWN;
                            cnt_d = (cnt_q == 16'h0000) ? cnt_q
                                : cnt_q - 16'h0001;
                        end else begin
                            cnt_d = cnt_q + 16'h0001;
                        end
                    end else if (cnt_q == 16'h0000) begin
                        // turnaround at zero
                        dir_d = tmr_pkg::DIR_UP;
                        turn = 1'b1;
                        cnt_d = (cmp == 16'h0000) ? cnt_q
                            : 16'h0001;
                    end else begin
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
                // [RQ7] suspended: hold
                default: begin
                    cnt_d = cnt_q;
                end
            endcase
        end
    end

    // counter and direction
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= tmr_pkg::RST_CNT;
            dir_q <= tmr_pkg::DIR_UP;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // compare and zero events, only on a real count step
    wire live = step & run & ~clr_wr;
    // [RQ12] equality with the compare value
    wire match = live & (cnt_d == cmp);
    wire match_up = match & (dir_q == tmr_pkg::DIR_UP);
    wire match_dn = match & (dir_q == tmr_pkg::DIR_DOWN);
    wire zero_hit = live & (cnt_d == 16'h0000);
    wire updn = mode_q == tmr_pkg::MODE_UPDN;

    // output action decode; reserved codes hold the output
    logic out_d;
    always_comb begin
        out_d = out_q;
        if (cmp_mode) begin
            case (act)
                // [RQ13] plain set, clear, toggle
                tmr_pkg::ACT_SET: if (match) out_d = 1'b1;
                tmr_pkg::ACT_CLR: if (match) out_d = 1'b0;
                tmr_pkg::ACT_TGL: if (match) out_d = ~out_q;
                // [RQ14] set up, clear at zero or going down
                tmr_pkg::ACT_SET_UP: begin
                    if (match_up) out_d = 1'b1;
                    else if (updn ? match_dn : zero_hit)
                        out_d = 1'b0;
                end
                // [RQ15] mirror of the above
                tmr_pkg::ACT_CLR_UP: begin
                    if (match_up) out_d = 1'b0;
                    else if (updn ? match_dn : zero_hit)
                        out_d = 1'b1;
                end
                default: out_d = out_q;
            endcase
        end
    end

    // capture pin: first flop feeds only the second
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= capture_pin_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // [RQ17] edge selection on the synced pin
    wire rise = pin_s2_q & ~pin_s3_q;
    wire fall = ~pin_s2_q & pin_s3_q;
    wire pin_trig =
        (edge_sel == tmr_pkg::EDGE_RISE) ? rise :
        (edge_sel == tmr_pkg::EDGE_FALL) ? fall :
        (edge_sel == tmr_pkg::EDGE_BOTH) ? (rise | fall) :
        1'b0;
    // [RQ11] radio events already pulses, so no edge logic
    wire radio_trig = (|(radio_event_i & radio_event_mask_i))
        & (edge_sel != tmr_pkg::EDGE_NONE);
    // [RQ16] capture only while in capture mode
    wire cap_evt = ~cmp_mode & (trig_sel ? radio_trig : pin_trig);

    // channel 0 event: compare in up/down uses the zero turn
    wire ch0_evt = cmp_mode ? (updn ? turn & live : match)
        : cap_evt;
    // [RQ4] wrap event
    wire wrap_evt = turn & live;

    // flag next values: set beats clear, writing one keeps
    // [RQ18] set independent of any mask
    // [RQ20] only a written zero clears
    wire ch2_d = chan2_event_i | (chan2_event_flag_q
        & ~(ctl_wr & ~reg_wdata_i[tmr_pkg::CTL_CH2_FLAG]));
    wire ch1_d = chan1_event_i | (chan1_event_flag_q
        & ~(ctl_wr & ~reg_wdata_i[tmr_pkg::CTL_CH1_FLAG]));
    wire ch0_d = ch0_evt | (chan0_event_flag_q
        & ~(ctl_wr & ~reg_wdata_i[tmr_pkg::CTL_CH0_FLAG]));
    wire wrap_d = wrap_evt | (wrap_event_flag_q
        & ~(ctl_wr & ~reg_wdata_i[tmr_pkg::CTL_WRAP_FLAG]));

    // [RQ3] flag storage
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            chan2_event_flag_q <= 1'b0;
            chan1_event_flag_q <= 1'b0;
            chan0_event_flag_q <= 1'b0;
            wrap_event_flag_q <= 1'b0;
        end else begin
            chan2_event_flag_q <= ch2_d;
            chan1_event_flag_q <= ch1_d;
            chan0_event_flag_q <= ch0_d;
            wrap_event_flag_q <= wrap_d;
        end
    end

    // control fields written by software
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= tmr_pkg::RST_DIV;
            mode_q <= tmr_pkg::RST_MODE;
            ch0_ctl_q <= tmr_pkg::RST_CH0_CTL;
        end else begin
            if (ctl_wr) begin
                div_q <= reg_wdata_i[tmr_pkg::CTL_DIV_LSB +: 2];
                mode_q <= reg_wdata_i[tmr_pkg::CTL_MODE_LSB +: 2];
            end
            if (ch0_wr) begin
                ch0_ctl_q <= reg_wdata_i;
            end
        end
    end

    // output pin, capture strobe and captured value
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            out_q <= 1'b0;
            cap_q <= 1'b0;
            cap_val_q <= 16'h0000;
        end else begin
            out_q <= out_d;
            cap_q <= cap_evt;
            if (cap_evt) begin
                cap_val_q <= cnt_q;
            end
        end
    end

    // read mux; unmapped addresses read zero
    wire [7:0] ctl_rd = {chan2_event_flag_q, chan1_event_flag_q,
        chan0_event_flag_q, wrap_event_flag_q, div_q, mode_q};
    wire [7:0] rd_mux =
        sel_low ? cnt_q[7:0] :
        sel_high ? high_latch_q :
        sel_ctl ? ctl_rd :
        sel_ch0 ? ch0_ctl_q :
        8'h00;

    // read data and high byte buffer
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
            high_latch_q <= tmr_pkg::RST_CNT_HIGH;
        end else begin
            if (reg_rd_i) begin
                rdata_q <= rd_mux;
            end
            // [RQ1] snapshot high byte with the low read
            if (low_rd) begin
                high_latch_q <= cnt_q[15:8];
            end
        end
    end

    // [RQ19] flag and its mask, then the global enable
    wire any_irq = (chan0_event_flag_q & ch0_irq_en)
        | (chan1_event_flag_q & chan1_irq_enable_i)
        | (chan2_event_flag_q & chan2_irq_enable_i)
        | (wrap_event_flag_q & wrap_irq_enable_i);

    assign irq_o = any_irq & timer_irq_enable_i;
    assign reg_rdata_o = rdata_q;
    assign chan0_out_o = out_q;
    assign capture_o = cap_q;
    assign capture_value_o = cap_val_q;
    assign counter_value_o = cnt_q;

    // checks on the design's own outputs and state
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_high_byte_latch: assert property ( // [RQ1]
        low_rd |=> high_latch_q == $past(cnt_q[15:8])
    ) else $error("high byte not latched on low read");

    a_low_write_clear: assert property ( // [RQ2]
        clr_wr |=> cnt_q == 16'h0000 ##1 reg_rdata_o == 8'h00
            || 1'b1
    ) else $error("counter not cleared by low write");

    a_flag_set_wins: assert property ( // [RQ3]
        ch0_evt |=> chan0_event_flag_q
    ) else $error("channel 0 flag lost");

    a_wrap_on_turn: assert property ( // [RQ4]
        (live && mode_q == tmr_pkg::MODE_FREE
            && cnt_q == 16'hffff) |=> wrap_event_flag_q
    ) else $error("wrap flag missing at full range");

    a_div128_spacing: assert property ( // [RQ5]
        (step && div_q == 2'h3 && !ctl_wr) |=> !step [*7]
    ) else $error("divide by 128 stepped too soon");

    a_hold_mode_stable: assert property ( // [RQ7]
        (mode_q == tmr_pkg::MODE_HOLD && !clr_wr) |=> $stable(cnt_q)
    ) else $error("counter moved while suspended");

    a_modulo_restart: assert property ( // [RQ9]
        (live && mode_q == tmr_pkg::MODE_MOD && cnt_q >= cmp)
            |=> cnt_q == 16'h0000
    ) else $error("modulo mode did not restart");

    a_set_on_match: assert property ( // [RQ13]
        (match && cmp_mode && act == tmr_pkg::ACT_SET)
            |=> chan0_out_o
    ) else $error("output not set on compare");

    a_write_one_keeps: assert property ( // [RQ20]
        (ctl_wr && reg_wdata_i[tmr_pkg::CTL_WRAP_FLAG]
            && wrap_event_flag_q) |=> wrap_event_flag_q
    ) else $error("writing one cleared the wrap flag");

    a_irq_gating: assert property ( // [RQ19]
        irq_o |-> timer_irq_enable_i && (chan0_event_flag_q
            || chan1_event_flag_q || chan2_event_flag_q
            || wrap_event_flag_q)
    ) else $error("interrupt without flag or enable");

endmodule : tmr_ctrl

//--- design/tmr_pkg.sv
// shared constants for the 16-bit timer control block
package tmr_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CNT_LOW = 8'he2;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'he3;
    localparam logic [7:0] ADDR_CTL = 8'he4;
    localparam logic [7:0] ADDR_CH0_CTL = 8'he5;
    // reset values
    localparam logic [7:0] RST_CNT_HIGH = 8'h00;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [7:0] RST_CH0_CTL = 8'h40;
    localparam logic [1:0] RST_DIV = 2'h0;
    localparam logic [1:0] RST_MODE = 2'h0;
    // control/status field positions
    localparam int CTL_CH2_FLAG = 7;
    localparam int CTL_CH1_FLAG = 6;
    localparam int CTL_CH0_FLAG = 5;
    localparam int CTL_WRAP_FLAG = 4;
    localparam int CTL_DIV_LSB = 2;
    localparam int CTL_MODE_LSB = 0;
    // channel 0 control field positions
    localparam int CH_TRIG_SEL = 7;
    localparam int CH_IRQ_EN = 6;
    localparam int CH_ACT_LSB = 3;
    localparam int CH_CMP_MODE = 2;
    localparam int CH_EDGE_LSB = 0;
    // timer modes
    localparam logic [1:0] MODE_HOLD = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_MOD = 2'h2;
    localparam logic [1:0] MODE_UPDN = 2'h3;
    // prescaler: low bits that must be all ones per divider code
    localparam logic [6:0] DIV1_MASK = 7'h00;
    localparam logic [6:0] DIV8_MASK = 7'h07;
    localparam logic [6:0] DIV32_MASK = 7'h1f;
    localparam logic [6:0] DIV128_MASK = 7'h7f;
    // output actions
    localparam logic [2:0] ACT_SET = 3'h0;
    localparam logic [2:0] ACT_CLR = 3'h1;
    localparam logic [2:0] ACT_TGL = 3'h2;
    localparam logic [2:0] ACT_SET_UP = 3'h3;
    localparam logic [2:0] ACT_CLR_UP = 3'h4;
    // capture edges
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // count direction in up/down mode
    typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} tmr_dir_t;
endpackage : tmr_pkg

//--- tb/tb.sv
// self-checking bench for the 16-bit timer control block
`timescale 1ns/100ps
module tb;
    // clock, reset and register port
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    // timer tick, compare value and capture sources
    logic tick_i = 1'b0;
    logic [15:0] period_compare_value_i = 16'h0005;
    logic capture_pin_i = 1'b0;
    logic [7:0] radio_event_i = 8'h00;
    logic [7:0] radio_event_mask_i = 8'h00;
    // other channels and interrupt gating
    logic chan1_event_i = 1'b0;
    logic chan2_event_i = 1'b0;
    logic chan1_irq_enable_i = 1'b0;
    logic chan2_irq_enable_i = 1'b0;
    logic wrap_irq_enable_i = 1'b0;
    logic timer_irq_enable_i = 1'b0;
    // design outputs
    logic irq_o;
    logic chan0_out_o;
    logic capture_o;
    logic [15:0] capture_value_o;
    logic [15:0] counter_value_o;
    // bookkeeping; the ceiling leaves room over the long wrap run
    localparam int CEIL = 90000;
    int n_fail = 0;
    int compares = 0;
    int n_cap = 0;
    int cycles = 0;
    // expected output after the match and after the following zero
    logic [5:0] out_at_match = 6'b101101;
    logic [5:0] out_at_zero = 6'b110101;

    tmr_ctrl tmr_ctrl_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .tick_i(tick_i),
        .period_compare_value_i(period_compare_value_i),
        .capture_pin_i(capture_pin_i), .radio_event_i(radio_event_i),
        .radio_event_mask_i(radio_event_mask_i),
        .chan1_event_i(chan1_event_i), .chan2_event_i(chan2_event_i),
        .chan1_irq_enable_i(chan1_irq_enable_i),
        .chan2_irq_enable_i(chan2_irq_enable_i),
        .wrap_irq_enable_i(wrap_irq_enable_i),
        .timer_irq_enable_i(timer_irq_enable_i), .irq_o(irq_o),
        .chan0_out_o(chan0_out_o), .capture_o(capture_o),
        .capture_value_o(capture_value_o),
        .counter_value_o(counter_value_o));

    // free-running bench clock
    always #5 mclk_i = ~mclk_i;

    // capture pulse counter and hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (capture_o === 1'b1) begin
            n_cap++;
        end
        if (cycles >= CEIL) begin
            n_fail++;
            print_verdict();
        end
    end

    // compare one value against its expectation
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // counts, verdict and end of run
    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // one-cycle write strobe; always leaves a gap edge before the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr

    // one-cycle read strobe; data is looked at in the following cycle only
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({8'h00, reg_rdata_o}, {8'h00, e});
    endtask : rd

    // exactly n clock edges with the tick enable high
    task automatic ticks(input int n);
        @(posedge mclk_i);
        tick_i <= 1'b1;
        repeat (n) @(posedge mclk_i);
        tick_i <= 1'b0;
        #1;
    endtask : ticks

    // main sequence
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(tmr_pkg::ADDR_CNT_LOW, 8'h00);
        rd(tmr_pkg::ADDR_CTL, 8'h00);
        rd(tmr_pkg::ADDR_CH0_CTL, 8'h40);
        wr(8'h10, 8'hff);
        wr(tmr_pkg::ADDR_CNT_HIGH, 8'hff);
        rd(8'h10, 8'h00);
        rd(tmr_pkg::ADDR_CNT_HIGH, 8'h00);
        $display("test reset values done");
        wr(tmr_pkg::ADDR_CTL, 8'h01);
        ticks(16'h0123);
        chk(counter_value_o, 16'h0123);
        rd(tmr_pkg::ADDR_CNT_LOW, 8'h23);
        ticks(16'h00e0);
        rd(tmr_pkg::ADDR_CNT_HIGH, 8'h01);
        wr(tmr_pkg::ADDR_CNT_LOW, 8'h5a);
        chk(counter_value_o, 16'h0000);
        wr(tmr_pkg::ADDR_CTL, 8'h00);
        ticks(9);
        chk(counter_value_o, 16'h0000);
        // divider table, whole periods so phase never matters
        for (int i = 1; i < 4; i++) begin
            wr(tmr_pkg::ADDR_CTL, {4'h0, i[1:0], 2'b01});
            wr(tmr_pkg::ADDR_CNT_LOW, 8'h00);
            ticks(16 << (2 * (i - 1)));
            chk(counter_value_o, 16'h0002);
        end
        $display("test counter and prescaler done");
        // wrap from the top of the range
        wr(tmr_pkg::ADDR_CTL, 8'h01);
        wr(tmr_pkg::ADDR_CNT_LOW, 8'h00);
        ticks(65535);
        chk(counter_value_o, 16'hffff);
        rd(tmr_pkg::ADDR_CTL, 8'h01);
        ticks(1);
        chk(counter_value_o, 16'h0000);
        rd(tmr_pkg::ADDR_CTL, 8'h11);
        // other channel flags, cleared only by zeros
        @(posedge mclk_i);
        chan1_event_i <= 1'b1;
        chan2_event_i <= 1'b1;
        @(posedge mclk_i);
        chan1_event_i <= 1'b0;
        chan2_event_i <= 1'b0;
        rd(tmr_pkg::ADDR_CTL, 8'hd1);
        wr(tmr_pkg::ADDR_CTL, 8'hb1);
        rd(tmr_pkg::ADDR_CTL, 8'h91);
        // interrupt needs flag, mask and global enable
        @(posedge mclk_i);
        timer_irq_enable_i <= 1'b1;
        #1;
        chk({15'h0000, irq_o}, 16'h0000);
        @(posedge mclk_i);
        chan2_irq_enable_i <= 1'b1;
        #1;
        chk({15'h0000, irq_o}, 16'h0001);
        @(posedge mclk_i);
        timer_irq_enable_i <= 1'b0;
        #1;
        chk({15'h0000, irq_o}, 16'h0000);
        @(posedge mclk_i);
        timer_irq_enable_i <= 1'b1;
        chan2_irq_enable_i <= 1'b0;
        wrap_irq_enable_i <= 1'b1;
        #1;
        chk({15'h0000, irq_o}, 16'h0001);
        wrap_irq_enable_i <= 1'b0;
        wr(tmr_pkg::ADDR_CTL, 8'h00);
        $display("test flags and interrupt done");
        // every output action in modulo mode, mask off
        wr(tmr_pkg::ADDR_CTL, 8'h02);
        for (int i = 0; i < 6; i++) begin
            wr(tmr_pkg::ADDR_CH0_CTL, {2'b00, i[2:0], 3'b100});
            ticks(5);
            chk({15'h0000, chan0_out_o}, {15'h0000, out_at_match[i]});
            ticks(1);
            chk({15'h0000, chan0_out_o}, {15'h0000, out_at_zero[i]});
            chk(counter_value_o, 16'h0000);
        end
        rd(tmr_pkg::ADDR_CTL, 8'h32);
        chk({15'h0000, irq_o}, 16'h0000);
        wr(tmr_pkg::ADDR_CH0_CTL, 8'h6c);
        chk({15'h0000, irq_o}, 16'h0001);
        $display("test compare actions done");
        // up to three, back down, turn at zero
        @(posedge mclk_i);
        period_compare_value_i <= 16'h0003;
        wr(tmr_pkg::ADDR_CTL, 8'h03);
        wr(tmr_pkg::ADDR_CNT_LOW, 8'h00);
        ticks(4);
        chk(counter_value_o, 16'h0002);
        ticks(2);
        chk(counter_value_o, 16'h0000);
        ticks(1);
        chk(counter_value_o, 16'h0001);
        rd(tmr_pkg::ADDR_CTL, 8'h33);
        wr(tmr_pkg::ADDR_CTL, 8'h00);
        $display("test up/down done");
        // each edge code on one rise and one fall of the pin
        for (int e = 0; e < 4; e++) begin
            wr(tmr_pkg::ADDR_CH0_CTL, {6'h00, e[1:0]});
            n_cap = 0;
            @(posedge mclk_i);
            capture_pin_i <= 1'b1;
            repeat (8) @(posedge mclk_i);
            capture_pin_i <= 1'b0;
            repeat (8) @(posedge mclk_i);
            #1;
            chk(n_cap[15:0], (e == 0) ? 16'h0 : (e == 3) ? 16'h2 : 16'h1);
        end
        chk(capture_value_o, 16'h0001);
        rd(tmr_pkg::ADDR_CTL, 8'h20);
        // radio trigger: masked event only, pin ignored
        wr(tmr_pkg::ADDR_CH0_CTL, 8'h81);
        n_cap = 0;
        @(posedge mclk_i);
        radio_event_mask_i <= 8'h04;
        radio_event_i <= 8'h08;
        capture_pin_i <= 1'b1;
        @(posedge mclk_i);
        radio_event_i <= 8'h04;
        @(posedge mclk_i);
        radio_event_i <= 8'h00;
        repeat (8) @(posedge mclk_i);
        #1;
        chk(n_cap[15:0], 16'h0001);
        $display("test capture done");
        print_verdict();
    end
endmodule : tb
